// file: src/sys_gpadc_defs.svh
// register offsets, field positions, reset values and timing counts
`ifndef SYS_GPADC_DEFS_SVH
`define SYS_GPADC_DEFS_SVH
`define OFS_SYS_STATUS 8'hD6
`define OFS_SYS_CLEAR 8'hD7
`define OFS_SYS_MASK 8'hD8
`define OFS_AUTO_CTRL 8'hE1
`define OFS_MAN_CTRL 8'hE2
`define OFS_DEBOUNCE 8'hE3
`define OFS_CONV_STATUS 8'hE4
`define OFS_CONV_CLEAR 8'hE5
`define OFS_CONV_MASK 8'hE6
`define OFS_MAN_LOW 8'hE7
`define OFS_MAN_HIGH 8'hE8
`define OFS_SUPPLY_RES 8'hE9
`define OFS_TEMP_RES 8'hEA
`define OFS_TEMP_CAL 8'hEB
`define OFS_AUX2_RES 8'hEC
`define OFS_AUX2_HIGH 8'hED
`define OFS_AUX2_LOW 8'hEE
`define OFS_AUX3_RES 8'hEF
`define OFS_AUX3_HIGH 8'hF0
`define OFS_AUX3_LOW 8'hF1
`define OFS_CHIP_REV 8'hF2
`define SYS_EVT_MASK_BITS 8'h1F
`define CONV_EVT_MASK_BITS 8'h1F
`define AUTO_CTRL_BITS 8'h37
`define MAN_CTRL_BITS 8'hD0
`define DEBOUNCE_BITS 8'h06
`define REG_RESET 8'h00
`define BIT_SUMMARY_IRQ 7
`define BIT_MAN_RUN 4
`define BIT_SUPPLY_EN 0
`define BIT_AUX2_EN 1
`define BIT_AUX3_EN 2
`define BIT_AUX2_DB 1
`define BIT_AUX3_DB 2
`define FLG_SUPPLY_UNDER 0
`define FLG_TEMP_OVER 1
`define FLG_AUX2_TH 2
`define FLG_AUX3_TH 3
`define FLG_MAN_EOC 4
`define DEBOUNCE_COUNT 2'd3
`define AUTO_PERIOD_US 100
`define AUTO_PERIOD_CYCLES (`AUTO_PERIOD_US * 1000 / 10)
`endif

// file: src/sys_gpadc_pkg.sv
// types shared by the system event and converter control block
package sys_gpadc_pkg;
   typedef enum logic [1:0] {CH_SUPPLY, CH_TEMP, CH_AUX2, CH_AUX3} channel_t;
   typedef enum logic [1:0] {SRC_OFF, SRC_ON, SRC_MEASURE, SRC_OFF2} isrc_mode_t;
   typedef enum {CONV_IDLE, CONV_BUSY} conv_state_t;
endpackage

// file: src/sys_gpadc_ctrl.sv
// system event status and general purpose converter control
`timescale 1ns/1ps
`include "sys_gpadc_defs.svh"
module sys_gpadc_ctrl #(
   parameter int AUTO_PERIOD = `AUTO_PERIOD_CYCLES,
   parameter logic [7:0] CHIP_REV = 8'h11, // arbitrary value
   parameter logic [7:0] TEMP_CAL = 8'h00, // trimmed per part
   parameter logic [7:0] SUPPLY_UNDER_TH = 8'h80,
   parameter logic [7:0] TEMP_OVER_TH = 8'hC0
) (
   input wire logic ref_clk, // 100 MHz clock
   input wire logic rstn, // async reset, active low
   input wire logic supply_low_pin, // comparator: supply below 4 V
   input wire logic supply_high_pin, // comparator: supply above 5.5 V
   input wire logic die_hot_pin, // over-temperature detector
   input wire logic button_pulse_sleep, // short button pulse in sleep state
   input wire logic button_pulse_running, // short button pulse in running state
   input wire logic reg_wr, // register write strobe
   input wire logic reg_rd, // register read strobe
   input wire logic [7:0] reg_addr, // register offset
   input wire logic [7:0] reg_wdata, // write data
   output logic [7:0] reg_rdata, // read data, zero for unmapped
   output logic conv_start, // one-cycle request to the converter
   output sys_gpadc_pkg::channel_t conv_channel, // channel being converted
   input wire logic conv_done, // converter finished, result valid
   input wire logic [9:0] conv_result, // converter result
   output logic aux_two_source_on, // aux two current source enable
   output logic irq_out, // open-drain interrupt: low level
   output logic irq_oe // output enable, low while driving
);
   logic [7:0] sys_flags, sys_mask, auto_ctrl, man_ctrl, db_ctrl;
   logic [7:0] conv_flags, conv_mask;
   logic [7:0] man_low, man_high, supply_res, temp_res, aux2_res, aux3_res;
   logic [7:0] aux2_hi, aux2_lo, aux3_hi, aux3_lo;
   logic [4:0] ev_s1, ev_s2;
   logic [31:0] period_cnt;
   logic [1:0] scan_idx;
   logic [1:0] cnt_supply, cnt_temp, cnt_aux2, cnt_aux3;
   logic conv_manual, busy;
   sys_gpadc_pkg::conv_state_t state;

   // event pins come from the analog side, synchronise first
   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
      begin
         ev_s1 <= 5'h00;
         ev_s2 <= 5'h00;
      end
      else
      begin
         ev_s1 <= {button_pulse_running, button_pulse_sleep, die_hot_pin,
                   supply_high_pin, supply_low_pin};
         ev_s2 <= ev_s1;
      end

   wire wr_sys_clr = reg_wr && reg_addr == `OFS_SYS_CLEAR;
   wire wr_conv_clr = reg_wr && reg_addr == `OFS_CONV_CLEAR;
   wire wr_man = reg_wr && reg_addr == `OFS_MAN_CTRL;
   wire [7:0] sys_clr = wr_sys_clr ? (reg_wdata & `SYS_EVT_MASK_BITS) : 8'h00;
   wire [7:0] conv_clr = wr_conv_clr ? (reg_wdata & `CONV_EVT_MASK_BITS) : 8'h00;

   wire [7:0] next_sys_flags = (sys_flags & ~sys_clr) | {3'b000, ev_s2};
   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
         sys_flags <= `REG_RESET;
      else
         sys_flags <= next_sys_flags;

   wire [4:0] sys_pending = sys_flags[4:0] & ~sys_mask[4:0];
   wire [4:0] conv_pending = conv_flags[4:0] & ~conv_mask[4:0];
   wire irq_any = |sys_pending || |conv_pending;
   assign irq_out = 1'b0;
   assign irq_oe = ~irq_any;

   // plain control registers
   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
      begin
         sys_mask <= `REG_RESET;
         auto_ctrl <= `REG_RESET;
         db_ctrl <= `REG_RESET;
         conv_mask <= `REG_RESET;
         aux2_hi <= `REG_RESET;
         aux2_lo <= `REG_RESET;
         aux3_hi <= `REG_RESET;
         aux3_lo <= `REG_RESET;
      end
      else if (reg_wr)
      begin
         if (reg_addr == `OFS_SYS_MASK)
            sys_mask <= reg_wdata & `SYS_EVT_MASK_BITS;
         else if (reg_addr == `OFS_AUTO_CTRL)
            auto_ctrl <= reg_wdata & `AUTO_CTRL_BITS;
         else if (reg_addr == `OFS_DEBOUNCE)
            db_ctrl <= reg_wdata & `DEBOUNCE_BITS;
         else if (reg_addr == `OFS_CONV_MASK)
            conv_mask <= reg_wdata & `CONV_EVT_MASK_BITS;
         else if (reg_addr == `OFS_AUX2_HIGH)
            aux2_hi <= reg_wdata;
         else if (reg_addr == `OFS_AUX2_LOW)
            aux2_lo <= reg_wdata;
         else if (reg_addr == `OFS_AUX3_HIGH)
            aux3_hi <= reg_wdata;
         else if (reg_addr == `OFS_AUX3_LOW)
            aux3_lo <= reg_wdata;
      end

   // any automatic flag halts the scan
   wire auto_halt = |conv_flags[3:0];
   wire [2:0] auto_en = {auto_ctrl[`BIT_AUX3_EN], auto_ctrl[`BIT_AUX2_EN],
                         auto_ctrl[`BIT_SUPPLY_EN]};
   wire period_tick = period_cnt == 32'(AUTO_PERIOD - 1);
   // manual start blocked while done flag stands
   wire man_req = man_ctrl[`BIT_MAN_RUN] && !conv_flags[`FLG_MAN_EOC];
   wire auto_req = period_tick && !auto_halt && |auto_en;
   // temperature is scanned whenever any automatic channel runs
   wire [3:0] scan_set = {auto_en[2], auto_en[1], 1'b1, auto_en[0]};
   wire [1:0] next_idx_a = scan_idx + 2'd1;
   wire [1:0] next_idx_b = scan_idx + 2'd2;
   wire [1:0] next_idx_c = scan_idx + 2'd3;
   wire [1:0] next_scan = scan_set[next_idx_a] ? next_idx_a :
                          scan_set[next_idx_b] ? next_idx_b :
                          scan_set[next_idx_c] ? next_idx_c : scan_idx;

   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
         period_cnt <= 32'h0000_0000;
      else if (period_tick)
         period_cnt <= 32'h0000_0000;
      else
         period_cnt <= period_cnt + 32'h0000_0001;

   // manual work takes priority; a skipped automatic tick waits a period
   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
      begin
         state <= sys_gpadc_pkg::CONV_IDLE;
         conv_start <= 1'b0;
         conv_manual <= 1'b0;
         conv_channel <= sys_gpadc_pkg::CH_SUPPLY;
         scan_idx <= 2'd3;
      end
      else
      begin
         conv_start <= 1'b0;
         case (state)
            sys_gpadc_pkg::CONV_IDLE:
               if (man_req)
               begin
                  state <= sys_gpadc_pkg::CONV_BUSY;
                  conv_start <= 1'b1;
                  conv_manual <= 1'b1;
                  conv_channel <= sys_gpadc_pkg::channel_t'(man_ctrl[7:6]);
               end
               else if (auto_req)
               begin
                  state <= sys_gpadc_pkg::CONV_BUSY;
                  conv_start <= 1'b1;
                  conv_manual <= 1'b0;
                  conv_channel <= sys_gpadc_pkg::channel_t'(next_scan);
                  scan_idx <= next_scan;
               end
            sys_gpadc_pkg::CONV_BUSY:
               if (conv_done)
                  state <= sys_gpadc_pkg::CONV_IDLE;
            default:
               state <= sys_gpadc_pkg::CONV_IDLE;
         endcase
      end
   assign busy = state == sys_gpadc_pkg::CONV_BUSY;

   wire man_finish = busy && conv_done && conv_manual;
   wire auto_finish = busy && conv_done && !conv_manual;
   wire [7:0] res8 = conv_result[9:2];

   // manual run bit cleared by hardware on completion
   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
         man_ctrl <= `REG_RESET;
      else if (man_finish)
         man_ctrl <= man_ctrl & ~(8'h01 << `BIT_MAN_RUN);
      else if (wr_man)
         man_ctrl <= reg_wdata & `MAN_CTRL_BITS;

   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
      begin
         man_low <= `REG_RESET;
         man_high <= `REG_RESET;
      end
      else if (man_finish)
      begin
         man_low <= conv_result[7:0];
         man_high <= {6'b000000, conv_result[9:8]};
      end

   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
      begin
         supply_res <= `REG_RESET;
         temp_res <= `REG_RESET;
         aux2_res <= `REG_RESET;
         aux3_res <= `REG_RESET;
      end
      else if (auto_finish)
      begin
         if (conv_channel == sys_gpadc_pkg::CH_SUPPLY)
            supply_res <= res8;
         else if (conv_channel == sys_gpadc_pkg::CH_TEMP)
            temp_res <= res8;
         else if (conv_channel == sys_gpadc_pkg::CH_AUX2)
            aux2_res <= res8;
         else
            aux3_res <= res8;
      end

   // fixed internal limits for supply and temperature
   wire hit_supply = res8 < SUPPLY_UNDER_TH;
   wire hit_temp = res8 > TEMP_OVER_TH;
   wire hit_aux2 = res8 > aux2_hi || res8 < aux2_lo;
   wire hit_aux3 = res8 > aux3_hi || res8 < aux3_lo;
   wire fin_supply = auto_finish && conv_channel == sys_gpadc_pkg::CH_SUPPLY;
   wire fin_temp = auto_finish && conv_channel == sys_gpadc_pkg::CH_TEMP;
   wire fin_aux2 = auto_finish && conv_channel == sys_gpadc_pkg::CH_AUX2;
   wire fin_aux3 = auto_finish && conv_channel == sys_gpadc_pkg::CH_AUX3;

   wire set_supply = fin_supply && hit_supply && cnt_supply == `DEBOUNCE_COUNT - 2'd1;
   wire set_temp = fin_temp && hit_temp && cnt_temp == `DEBOUNCE_COUNT - 2'd1;
   wire set_aux2 = fin_aux2 && hit_aux2 &&
                   (!db_ctrl[`BIT_AUX2_DB] || cnt_aux2 == `DEBOUNCE_COUNT - 2'd1);
   wire set_aux3 = fin_aux3 && hit_aux3 &&
                   (!db_ctrl[`BIT_AUX3_DB] || cnt_aux3 == `DEBOUNCE_COUNT - 2'd1);
   // done flag set on manual completion
   wire [7:0] conv_set = {3'b000, man_finish, set_aux3, set_aux2, set_temp, set_supply};

   // hit counters; a miss restarts the run and a set consumes it
   // so a debounced flag cleared during a long excursion needs three fresh results
   wire [1:0] next_cnt_supply = (!hit_supply || set_supply) ? 2'd0 : cnt_supply + 2'd1;
   wire [1:0] next_cnt_temp = (!hit_temp || set_temp) ? 2'd0 : cnt_temp + 2'd1;
   wire [1:0] next_cnt_aux2 = (!hit_aux2 || set_aux2) ? 2'd0 : cnt_aux2 + 2'd1;
   wire [1:0] next_cnt_aux3 = (!hit_aux3 || set_aux3) ? 2'd0 : cnt_aux3 + 2'd1;
   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
      begin
         cnt_supply <= 2'd0;
         cnt_temp <= 2'd0;
         cnt_aux2 <= 2'd0;
         cnt_aux3 <= 2'd0;
      end
      else
      begin
         if (fin_supply)
            cnt_supply <= next_cnt_supply;
         if (fin_temp)
            cnt_temp <= next_cnt_temp;
         if (fin_aux2)
            cnt_aux2 <= next_cnt_aux2;
         if (fin_aux3)
            cnt_aux3 <= next_cnt_aux3;
      end

   wire [7:0] next_conv_flags = (conv_flags & ~conv_clr) | conv_set;
   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
         conv_flags <= `REG_RESET;
      else
         conv_flags <= next_conv_flags;

   wire [1:0] isrc = auto_ctrl[5:4];
   assign aux_two_source_on = isrc == sys_gpadc_pkg::SRC_ON ||
      (isrc == sys_gpadc_pkg::SRC_MEASURE && busy &&
       conv_channel == sys_gpadc_pkg::CH_AUX2);

   // read decode; unmapped offsets answer zero
   wire [7:0] status_rd = {irq_any, 2'b00, sys_flags[4:0]};
   always_ff @(posedge ref_clk or negedge rstn)
      if (!rstn)
         reg_rdata <= `REG_RESET;
      else if (reg_rd)
      begin
         if (reg_addr == `OFS_SYS_STATUS) reg_rdata <= status_rd;
         else if (reg_addr == `OFS_SYS_MASK) reg_rdata <= sys_mask;
         else if (reg_addr == `OFS_AUTO_CTRL) reg_rdata <= auto_ctrl;
         else if (reg_addr == `OFS_MAN_CTRL) reg_rdata <= man_ctrl;
         else if (reg_addr == `OFS_DEBOUNCE) reg_rdata <= db_ctrl;
         else if (reg_addr == `OFS_CONV_STATUS) reg_rdata <= conv_flags;
         else if (reg_addr == `OFS_CONV_MASK) reg_rdata <= conv_mask;
         else if (reg_addr == `OFS_MAN_LOW) reg_rdata <= man_low;
         else if (reg_addr == `OFS_MAN_HIGH) reg_rdata <= man_high;
         else if (reg_addr == `OFS_SUPPLY_RES) reg_rdata <= supply_res;
         else if (reg_addr == `OFS_TEMP_RES) reg_rdata <= temp_res;
         else if (reg_addr == `OFS_TEMP_CAL) reg_rdata <= TEMP_CAL;
         else if (reg_addr == `OFS_AUX2_RES) reg_rdata <= aux2_res;
         else if (reg_addr == `OFS_AUX2_HIGH) reg_rdata <= aux2_hi;
         else if (reg_addr == `OFS_AUX2_LOW) reg_rdata <= aux2_lo;
         else if (reg_addr == `OFS_AUX3_RES) reg_rdata <= aux3_res;
         else if (reg_addr == `OFS_AUX3_HIGH) reg_rdata <= aux3_hi;
         else if (reg_addr == `OFS_AUX3_LOW) reg_rdata <= aux3_lo;
         else if (reg_addr == `OFS_CHIP_REV) reg_rdata <= CHIP_REV;
         else reg_rdata <= 8'h00;
      end

   chk_sys_flag_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
      ev_s2[0] |=> sys_flags[0]) else $error("supply low event lost");
   chk_sys_clear_acts: assert property (@(posedge ref_clk) disable iff (!rstn)
      wr_sys_clr && reg_wdata[2] && !ev_s2[2] |=> !sys_flags[2])
      else $error("system clear ignored");
   chk_irq_follows_mask: assert property (@(posedge ref_clk) disable iff (!rstn)
      sys_flags[3] && !sys_mask[3] |-> !irq_oe) else $error("unmasked flag no irq");
   chk_mask_blocks: assert property (@(posedge ref_clk) disable iff (!rstn)
      (sys_flags[4:0] & ~sys_mask[4:0]) == 5'h00 &&
      (conv_flags[4:0] & ~conv_mask[4:0]) == 5'h00 |-> irq_oe)
      else $error("masked event raised irq");
   sequence man_done_s;
      busy && conv_manual && conv_done;
   endsequence
   chk_man_run_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
      man_done_s |=> !man_ctrl[4] && conv_flags[4]) else $error("manual end wrong");
   chk_eoc_blocks: assert property (@(posedge ref_clk) disable iff (!rstn)
      conv_flags[4] && !busy |=> !(conv_start && conv_manual))
      else $error("manual start while done set");
   chk_halt_auto: assert property (@(posedge ref_clk) disable iff (!rstn)
      |conv_flags[3:0] && !busy |=> !(conv_start && !conv_manual))
      else $error("auto ran while halted");
   chk_man_split: assert property (@(posedge ref_clk) disable iff (!rstn)
      man_done_s |=> man_low == $past(conv_result[7:0]) &&
      man_high == {6'b000000, $past(conv_result[9:8])})
      else $error("manual result split wrong");
   chk_temp_three: assert property (@(posedge ref_clk) disable iff (!rstn)
      $rose(conv_flags[1]) |-> $past(cnt_temp) == 2'd2) else $error("temp flag early");
   chk_supply_three: assert property (@(posedge ref_clk) disable iff (!rstn)
      $rose(conv_flags[0]) |-> $past(cnt_supply) == 2'd2) else $error("supply flag early");
   chk_aux_debounce: assert property (@(posedge ref_clk) disable iff (!rstn)
      $rose(conv_flags[2]) && $past(db_ctrl[1]) |-> $past(cnt_aux2) == 2'd2)
      else $error("aux two flag early");
   chk_isrc_on: assert property (@(posedge ref_clk) disable iff (!rstn)
      auto_ctrl[5:4] == 2'b01 |-> aux_two_source_on) else $error("source off");
   chk_start_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
      conv_start |=> !conv_start) else $error("start pulse too long");
endmodule // sys_gpadc_ctrl

// file: sim/system_irq_and_gpadc_control_tb.sv
// self-checking bench for the system event and converter control block
`timescale 1ns/1ps
`include "sys_gpadc_defs.svh"
module system_irq_and_gpadc_control_tb;
   localparam logic [7:0] REV = 8'h5a; // arbitrary value
   localparam logic [7:0] CAL = 8'h3c;
   localparam logic [7:0] RW_ADDR [7] = '{8'hD8, 8'hE3, 8'hE6, 8'hED, 8'hEE, 8'hF0, 8'hF1};
   localparam logic [7:0] RW_MASK [7] = '{8'h1F, 8'h06, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   localparam logic [7:0] RO_ADDR [6] = '{8'hD6, 8'hE7, 8'hE9, 8'hEB, 8'hF2, 8'hDA};
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [4:0] sys_pin = 5'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic conv_start;
   sys_gpadc_pkg::channel_t conv_channel;
   logic conv_done = 1'b0;
   logic [9:0] conv_result = 10'h000;
   logic aux_two_source_on;
   logic irq_out;
   logic irq_oe;
   int mismatches = 0;
   int samples_checked = 0;
   int starts = 0;
   int conv_count [4] = '{default: 0};
   logic [9:0] chan_val [4] = '{default: 10'h000};
   logic [1:0] cur_mode = 2'b00;
   logic [7:0] rd;
   int unsigned seed_dummy;

   sys_gpadc_ctrl #(.AUTO_PERIOD(8), .CHIP_REV(REV), .TEMP_CAL(CAL)) u_sys_gpadc_ctrl (
      .ref_clk(ref_clk), .rstn(rstn), .supply_low_pin(sys_pin[0]),
      .supply_high_pin(sys_pin[1]), .die_hot_pin(sys_pin[2]),
      .button_pulse_sleep(sys_pin[3]), .button_pulse_running(sys_pin[4]),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_channel(conv_channel),
      .conv_done(conv_done), .conv_result(conv_result),
      .aux_two_source_on(aux_two_source_on), .irq_out(irq_out), .irq_oe(irq_oe));

   always #5 ref_clk = ~ref_clk;

   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check1(input string what, input logic exp, input logic got);
      check8(what, {7'h00, exp}, {7'h00, got});
   endtask

   task automatic results();
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   function automatic logic [7:0] reset_value(input logic [7:0] a);
      if (a == `OFS_CHIP_REV)
         return REV;
      if (a == `OFS_TEMP_CAL)
         return CAL;
      return `REG_RESET;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask

   task automatic rdreg(input logic [7:0] a);
      @(negedge ref_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      rd = reg_rdata;
   endtask

   task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] e);
      rdreg(a);
      check8(what, e, rd);
   endtask

   // polls the converter status, bounded so a missing flag cannot hang the run
   task automatic wait_flag(input int b);
      int n;
      n = 0;
      rdreg(`OFS_CONV_STATUS);
      while (rd[b] !== 1'b1 && n < 200)
      begin
         rdreg(`OFS_CONV_STATUS);
         n++;
      end
   endtask

   task automatic auto_case(input string what, input logic [7:0] ctrl, input int b,
                            input int ch, input int n, input logic [7:0] ra);
      int s;
      conv_count = '{default: 0};
      cur_mode = ctrl[5:4];
      wr(`OFS_AUTO_CTRL, ctrl);
      wait_flag(b);
      check1(what, 1'b1, rd[b]);
      check8("runs before flag", 8'(n), 8'(conv_count[ch]));
      check1("irq from converter", 1'b0, irq_oe);
      expect_reg("auto result", ra, chan_val[ch][9:2]);
      s = starts;
      repeat (60) @(negedge ref_clk);
      check8("starts while halted", 8'(s), 8'(starts));
      wr(`OFS_AUTO_CTRL, 8'h00);
      wr(`OFS_CONV_CLEAR, 8'h01 << b);
      expect_reg("flag cleared", `OFS_CONV_STATUS, 8'h00);
   endtask

   // converter stand-in: answers three cycles after each start
   initial
   begin
      forever
      begin
         @(negedge ref_clk);
         if (conv_start === 1'b1)
         begin
            starts++;
            conv_count[conv_channel]++;
            if (conv_channel == sys_gpadc_pkg::CH_AUX2)
               check1("source on", cur_mode == 2'b01 || cur_mode == 2'b10, aux_two_source_on);
            repeat (3) @(negedge ref_clk);
            conv_result <= chan_val[conv_channel];
            conv_done <= 1'b1;
            @(negedge ref_clk);
            conv_done <= 1'b0;
            conv_result <= ~chan_val[conv_channel];
         end
      end
   end

   initial
   begin
      // the tests need about a thousand cycles; 20000 leaves ample margin
      #200_000;
      mismatches++;
      results();
   end

   initial
   begin
      logic [7:0] v;
      int s;
      seed_dummy = $urandom(32'h117a_26ed);
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      rstn = 1'b1;
      for (int a = 8'hD6; a <= 8'hF2; a++)
         expect_reg("reset value", 8'(a), reset_value(8'(a)));
      check1("irq idle", 1'b1, irq_oe);
      // read-only and unmapped places ignore writes
      foreach (RO_ADDR[i])
      begin
         wr(RO_ADDR[i], ~reset_value(RO_ADDR[i]));
         expect_reg("read only", RO_ADDR[i], reset_value(RO_ADDR[i]));
      end
      foreach (RW_ADDR[i])
      begin
         v = 8'($urandom);
         wr(RW_ADDR[i], v);
         expect_reg("rw field", RW_ADDR[i], v & RW_MASK[i]);
      end
      wr(`OFS_SYS_MASK, 8'h00);
      wr(`OFS_CONV_MASK, 8'h00);
      for (int m = 0; m < 4; m++)
      begin
         wr(`OFS_AUTO_CTRL, 8'(m) << 4);
         expect_reg("source mode", `OFS_AUTO_CTRL, 8'(m) << 4);
         check1("idle source", m == 1, aux_two_source_on);
      end
      wr(`OFS_AUTO_CTRL, 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         @(negedge ref_clk);
         sys_pin[i] = 1'b1;
         @(negedge ref_clk);
         sys_pin[i] = 1'b0;
         repeat (4) @(negedge ref_clk);
         expect_reg("event flag", `OFS_SYS_STATUS, 8'h80 | (8'h01 << i));
         check1("irq open drain", 1'b0, irq_oe);
         check1("irq level", 1'b0, irq_out);
         wr(`OFS_SYS_MASK, 8'h01 << i);
         expect_reg("masked event", `OFS_SYS_STATUS, 8'h01 << i);
         check1("irq masked", 1'b1, irq_oe);
         wr(`OFS_SYS_MASK, 8'h00);
         wr(`OFS_SYS_CLEAR, ~(8'h01 << i));
         expect_reg("clear by zero", `OFS_SYS_STATUS, 8'h80 | (8'h01 << i));
         wr(`OFS_SYS_CLEAR, 8'h01 << i);
         expect_reg("clear by one", `OFS_SYS_STATUS, 8'h00);
      end
      for (int ch = 0; ch < 4; ch++)
      begin
         chan_val[ch] = (ch == 0) ? 10'h3ff : 10'($urandom);
         s = starts;
         wr(`OFS_MAN_CTRL, (8'(ch) << 6) | 8'h10);
         wait_flag(`FLG_MAN_EOC);
         check1("end of conversion", 1'b1, rd[4]);
         check8("channel", 8'(ch), {6'h00, conv_channel});
         expect_reg("run cleared", `OFS_MAN_CTRL, 8'(ch) << 6);
         expect_reg("result low", `OFS_MAN_LOW, chan_val[ch][7:0]);
         expect_reg("result high", `OFS_MAN_HIGH, {6'h00, chan_val[ch][9:8]});
         expect_reg("summary bit", `OFS_SYS_STATUS, 8'h80);
         wr(`OFS_CONV_MASK, 8'h10);
         check1("converter masked", 1'b1, irq_oe);
         wr(`OFS_CONV_MASK, 8'h00);
         // a second run must wait while the done flag stands
         wr(`OFS_MAN_CTRL, (8'(ch) << 6) | 8'h10);
         repeat (20) @(negedge ref_clk);
         check8("blocked start", 8'(s + 1), 8'(starts));
         wr(`OFS_CONV_CLEAR, 8'h10);
         wait_flag(`FLG_MAN_EOC);
         check8("resumed start", 8'(s + 2), 8'(starts));
         wr(`OFS_CONV_CLEAR, 8'h10);
      end
      chan_val[0] = 10'($urandom_range(0, 511));
      chan_val[1] = 10'($urandom_range(0, 767));
      auto_case("supply under", 8'h01, `FLG_SUPPLY_UNDER, 0, 3, `OFS_SUPPLY_RES);
      chan_val[0] = 10'($urandom_range(512, 1023));
      chan_val[1] = 10'($urandom_range(772, 1023));
      auto_case("temperature over", 8'h01, `FLG_TEMP_OVER, 1, 3, `OFS_TEMP_RES);
      chan_val[1] = 10'($urandom_range(0, 767));
      chan_val[2] = 10'($urandom_range(580, 1023));
      wr(`OFS_DEBOUNCE, 8'h02);
      wr(`OFS_AUX2_HIGH, 8'h90);
      wr(`OFS_AUX2_LOW, 8'h20);
      auto_case("aux two over", 8'h22, `FLG_AUX2_TH, 2, 3, `OFS_AUX2_RES);
      chan_val[3] = 10'($urandom_range(0, 255));
      wr(`OFS_DEBOUNCE, 8'h00);
      wr(`OFS_AUX3_HIGH, 8'hFF);
      wr(`OFS_AUX3_LOW, 8'h40);
      auto_case("aux three under", 8'h04, `FLG_AUX3_TH, 3, 1, `OFS_AUX3_RES);
      results();
   end
endmodule // system_irq_and_gpadc_control_tb
